// File: core/mes_pkg.sv
// Purpose: Shared constants for the motion and engine settings command handler.
// Assumes: Frames arrive least significant byte first, one byte per handshake.
// Notes: Checksum is a 16-bit sum of the payload between command word and checksum.
package mes_pkg;
  // Command words as they appear on the link, little endian.
  localparam logic [31:0] MES_CMD_SET_MOVE = 32'h766f6d73;
  localparam logic [31:0] MES_CMD_GET_MOVE = 32'h766f6d67;
  localparam logic [31:0] MES_CMD_SET_ENG = 32'h676e6573;
  // Frame lengths in bytes.
  localparam logic [5:0] MES_LEN_CMD = 6'h04;
  localparam logic [5:0] MES_LEN_MOVE = 6'h1e;
  localparam logic [5:0] MES_LEN_ENG = 6'h22;
  localparam int MES_BUF_BYTES = 34;
  localparam logic [5:0] MES_PAYLOAD_START = 6'h04;
  localparam logic [5:0] MES_CRC_BYTES = 6'h02;
  // Move settings byte positions.
  localparam int MES_MV_RATE = 4;
  localparam int MES_MV_FRAC = 8;
  localparam int MES_MV_ACC = 9;
  localparam int MES_MV_DEC = 11;
  localparam int MES_MV_BLRATE = 13;
  localparam int MES_MV_BLFRAC = 17;
  localparam logic [5:0] MES_MV_RSV_END = 6'h1b;
  localparam logic [5:0] MES_MV_CRC_LO = 6'h1c;
  localparam logic [5:0] MES_MV_CRC_HI = 6'h1d;
  // Engine settings byte positions.
  localparam int MES_EN_VOLT = 4;
  localparam int MES_EN_CURR = 6;
  localparam int MES_EN_RATE = 8;
  localparam int MES_EN_FRAC = 12;
  localparam int MES_EN_FLAGS = 13;
  localparam int MES_EN_BLCNT = 15;
  // Behaviour flag bit positions.
  localparam int MES_FL_REVERSE = 0;
  localparam int MES_FL_RMS = 1;
  localparam int MES_FL_MAXRATE = 2;
  localparam int MES_FL_BACKLASH = 3;
  localparam int MES_FL_RAMP = 4;
  localparam int MES_FL_VCAP = 5;
  localparam int MES_FL_CCAP = 6;
  localparam int MES_FL_RCAP = 7;
  // Largest accepted speed value.
  localparam logic [31:0] MES_RATE_MAX = 32'h000186a0;
  // Software register map, byte addresses.
  localparam logic [3:0] MES_REG_CTRL = 4'h0;
  localparam logic [3:0] MES_REG_STATUS = 4'h4;
  localparam logic [3:0] MES_REG_MAXRATE = 4'h8;
  localparam int MES_CTRL_DC = 0;
  localparam logic [31:0] MES_MAXRATE_RST = 32'h000186a0;
  typedef enum logic [1:0] {MES_ST_RX, MES_ST_CHK, MES_ST_TX} mes_state_t;
endpackage

// File: core/mes_settings_cmd.sv
// Purpose: Decodes move and engine settings frames and drives the settings outputs.
// Assumes: One clock, synchronous active high reset, host holds frame bytes in order.
// Notes: A frame with an unknown command word is dropped after its fourth byte.
// Functional notes
// (RQ1) Move write frame 30 bytes, 4-byte echo.
// (RQ2) Move write command word is 0x766F6D73.
// (RQ3) Target speed clamped to 100000.
// (RQ4) Fractional target speed used on stepper only.
// (RQ5) Acceleration and deceleration are 16-bit values.
// (RQ6) Backlash speed fraction used on stepper only.
// (RQ7) Move read request answered with 30 bytes.
// (RQ8) Engine write frame code 0x676E6573, fields stored.
// (RQ9) Voltage cap flag 0x20, DC motors only.
// (RQ10) Current cap flag 0x40, DC motors only.
// (RQ11) Rate cap flag 0x80 limits shaft speed.
// (RQ12) Flag 0x01 inverts feedback count direction.
// (RQ13) Flag 0x02 selects RMS current meaning.
// (RQ14) Flag 0x04 uses maximum achievable rate.
// (RQ15) Flag 0x08 enables backlash compensation.
// (RQ16) Backlash count used only when flag set.
// (RQ17) Flag 0x10 enables acceleration and deceleration ramps.
// (RQ18) Bad checksum frame leaves settings unchanged.
// (RQ19) Reserved bytes are ignored.
module mes_settings_cmd
  import mes_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic srst,
  // Host byte stream in.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Host byte stream out.
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Software register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Measurements from the drive.
  input wire logic [15:0] meas_voltage,
  input wire logic [15:0] meas_current,
  input wire logic [31:0] meas_shaft_rate,
  input wire logic shaft_dir_positive,
  // Effective settings towards the motion engine.
  output logic [31:0] eff_target_rate,
  output logic [7:0] target_rate_fraction,
  output logic [15:0] eff_accel,
  output logic [15:0] eff_decel,
  output logic [31:0] backlash_move_rate,
  output logic [7:0] backlash_move_rate_fraction,
  output logic [15:0] rated_motor_voltage,
  output logic [15:0] rated_motor_current,
  output logic [31:0] nominal_shaft_rate,
  output logic [7:0] rated_shaft_rate_fraction,
  output logic current_rms_meaning_flag,
  output logic backlash_enable,
  output logic [15:0] backlash_count,
  output logic feedback_count_up,
  output logic voltage_cap_hit,
  output logic current_cap_hit,
  output logic rate_cap_hit
);
  mes_state_t state_r;
  logic [7:0] rx_buf [0:MES_BUF_BYTES-1];
  logic [5:0] idx_r;
  logic [5:0] frame_len_r;
  logic [15:0] sum_r;
  logic is_engine_r;
  logic answer_r;
  logic [5:0] tx_len_r;
  logic [5:0] tx_idx_r;
  logic [7:0] tx_data_r;
  logic tx_valid_r;
  logic [31:0] cmd_word;
  logic crc_ok;
  logic [15:0] crc_rx;
  logic tx_fire;
  logic tx_last;
  // Stored settings.
  logic [31:0] target_rate_q;
  logic [7:0] target_frac_q;
  logic [15:0] accel_q;
  logic [15:0] decel_q;
  logic [31:0] bl_rate_q;
  logic [7:0] bl_frac_q;
  logic [15:0] volt_q;
  logic [15:0] curr_q;
  logic [31:0] rated_rate_q;
  logic [7:0] rated_frac_q;
  logic [15:0] flags_q;
  logic [15:0] bl_count_q;
  // Software registers.
  logic dc_motor_r;
  logic [31:0] max_rate_r;
  logic [7:0] bad_crc_cnt_r;
  logic [7:0] good_cnt_r;
  logic [31:0] reg_rdata_r;
  // Output flops.
  logic [31:0] eff_target_rate_r;
  logic [7:0] target_frac_r;
  logic [15:0] eff_accel_r;
  logic [15:0] eff_decel_r;
  logic [7:0] bl_frac_r;
  logic [31:0] nominal_rate_r;
  logic [7:0] rated_frac_r;
  logic backlash_enable_r;
  logic [15:0] backlash_count_r;
  logic feedback_up_r;
  logic vcap_r;
  logic ccap_r;
  logic rcap_r;

  assign cmd_word = {rx_data, rx_buf[2], rx_buf[1], rx_buf[0]};
  assign rx_ready = (state_r == MES_ST_RX);
  assign crc_rx = is_engine_r ?
                  {rx_buf[MES_LEN_ENG-1], rx_buf[MES_LEN_ENG-2]} :
                  {rx_buf[MES_MV_CRC_HI], rx_buf[MES_MV_CRC_LO]};
  assign crc_ok = (crc_rx == sum_r);
  assign tx_fire = tx_valid_r && tx_ready;
  assign tx_last = (tx_idx_r == tx_len_r - 6'h01);

  // Answer byte for a move read; the checksum covers bytes 4 to 27.
  function automatic logic [7:0] move_byte(input logic [5:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      6'h04: b = target_rate_q[7:0];
      6'h05: b = target_rate_q[15:8];
      6'h06: b = target_rate_q[23:16];
      6'h07: b = target_rate_q[31:24];
      6'h08: b = target_frac_q;
      6'h09: b = accel_q[7:0];
      6'h0a: b = accel_q[15:8];
      6'h0b: b = decel_q[7:0];
      6'h0c: b = decel_q[15:8];
      6'h0d: b = bl_rate_q[7:0];
      6'h0e: b = bl_rate_q[15:8];
      6'h0f: b = bl_rate_q[23:16];
      6'h10: b = bl_rate_q[31:24];
      6'h11: b = bl_frac_q;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  logic [15:0] ans_sum;
  always_comb begin
    ans_sum = 16'h0000;
    for (int k = MES_PAYLOAD_START; k <= MES_MV_RSV_END; k++) begin
      ans_sum = ans_sum + {8'h00, move_byte(6'(k))};
    end
  end

  function automatic logic [7:0] tx_byte(input logic [5:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (i < MES_LEN_CMD) begin
      b = rx_buf[i[1:0]];
    end else if (i == MES_MV_CRC_LO) begin
      b = ans_sum[7:0];
    end else if (i == MES_MV_CRC_HI) begin
      b = ans_sum[15:8];
    end else begin
      b = move_byte(i);
    end
    return b;
  endfunction

  // Receive buffer.
  always_ff @(posedge clock) begin
    if (rx_valid && rx_ready && idx_r < 6'(MES_BUF_BYTES)) begin
      rx_buf[idx_r] <= rx_data;
    end
  end

  // Frame sequencing.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= MES_ST_RX;
      idx_r <= 6'h00;
      frame_len_r <= MES_LEN_CMD;
      sum_r <= 16'h0000;
      is_engine_r <= 1'b0;
      answer_r <= 1'b0;
      tx_len_r <= MES_LEN_CMD;
      tx_idx_r <= 6'h00;
      tx_data_r <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      case (state_r)
        MES_ST_RX: begin
          if (rx_valid) begin
            idx_r <= idx_r + 6'h01;
            if (idx_r >= MES_PAYLOAD_START && idx_r < frame_len_r - MES_CRC_BYTES) begin
              sum_r <= sum_r + {8'h00, rx_data};
            end
            if (idx_r == MES_LEN_CMD - 6'h01) begin
              sum_r <= 16'h0000;
              if (cmd_word == MES_CMD_SET_MOVE) begin
                frame_len_r <= MES_LEN_MOVE; // RQ1 RQ2
                is_engine_r <= 1'b0;
              end else if (cmd_word == MES_CMD_SET_ENG) begin
                frame_len_r <= MES_LEN_ENG; // RQ8
                is_engine_r <= 1'b1;
              end else if (cmd_word == MES_CMD_GET_MOVE) begin
                state_r <= MES_ST_TX; // RQ7
                answer_r <= 1'b1;
                tx_len_r <= MES_LEN_MOVE;
                tx_idx_r <= 6'h00;
                tx_data_r <= rx_buf[0];
                tx_valid_r <= 1'b1;
                idx_r <= 6'h00;
              end else begin
                idx_r <= 6'h00;
              end
            end else if (idx_r > MES_LEN_CMD - 6'h01 && idx_r == frame_len_r - 6'h01) begin
              state_r <= MES_ST_CHK;
            end
          end
        end
        MES_ST_CHK: begin
          idx_r <= 6'h00;
          frame_len_r <= MES_LEN_CMD;
          if (crc_ok) begin
            state_r <= MES_ST_TX; // RQ1
            answer_r <= 1'b0;
            tx_len_r <= MES_LEN_CMD;
            tx_idx_r <= 6'h00;
            tx_data_r <= rx_buf[0];
            tx_valid_r <= 1'b1;
          end else begin
            state_r <= MES_ST_RX; // RQ18
          end
        end
        MES_ST_TX: begin
          if (tx_fire) begin
            if (tx_last) begin
              tx_valid_r <= 1'b0;
              state_r <= MES_ST_RX;
              sum_r <= 16'h0000;
            end else begin
              tx_idx_r <= tx_idx_r + 6'h01;
              tx_data_r <= tx_byte(tx_idx_r + 6'h01);
            end
          end
        end
        default: state_r <= MES_ST_RX;
      endcase
    end
  end

  // Settings commit; reserved bytes are never read.
  always_ff @(posedge clock) begin
    if (srst) begin
      target_rate_q <= 32'h00000000;
      target_frac_q <= 8'h00;
      accel_q <= 16'h0000;
      decel_q <= 16'h0000;
      bl_rate_q <= 32'h00000000;
      bl_frac_q <= 8'h00;
      volt_q <= 16'h0000;
      curr_q <= 16'h0000;
      rated_rate_q <= 32'h00000000;
      rated_frac_q <= 8'h00;
      flags_q <= 16'h0000;
      bl_count_q <= 16'h0000;
    end else if (state_r == MES_ST_CHK && crc_ok) begin // RQ18 RQ19
      if (!is_engine_r) begin
        target_rate_q <= {rx_buf[MES_MV_RATE+3], rx_buf[MES_MV_RATE+2],
                          rx_buf[MES_MV_RATE+1], rx_buf[MES_MV_RATE]};
        target_frac_q <= rx_buf[MES_MV_FRAC];
        accel_q <= {rx_buf[MES_MV_ACC+1], rx_buf[MES_MV_ACC]}; // RQ5
        decel_q <= {rx_buf[MES_MV_DEC+1], rx_buf[MES_MV_DEC]}; // RQ5
        bl_rate_q <= {rx_buf[MES_MV_BLRATE+3], rx_buf[MES_MV_BLRATE+2],
                      rx_buf[MES_MV_BLRATE+1], rx_buf[MES_MV_BLRATE]};
        bl_frac_q <= rx_buf[MES_MV_BLFRAC];
      end else begin
        volt_q <= {rx_buf[MES_EN_VOLT+1], rx_buf[MES_EN_VOLT]}; // RQ8
        curr_q <= {rx_buf[MES_EN_CURR+1], rx_buf[MES_EN_CURR]};
        rated_rate_q <= {rx_buf[MES_EN_RATE+3], rx_buf[MES_EN_RATE+2],
                         rx_buf[MES_EN_RATE+1], rx_buf[MES_EN_RATE]};
        rated_frac_q <= rx_buf[MES_EN_FRAC];
        flags_q <= {rx_buf[MES_EN_FLAGS+1], rx_buf[MES_EN_FLAGS]};
        bl_count_q <= {rx_buf[MES_EN_BLCNT+1], rx_buf[MES_EN_BLCNT]};
      end
    end
  end

  // Effective values; registered so the engine sees glitch-free settings.
  always_ff @(posedge clock) begin
    if (srst) begin
      eff_target_rate_r <= 32'h00000000;
      target_frac_r <= 8'h00;
      eff_accel_r <= 16'h0000;
      eff_decel_r <= 16'h0000;
      bl_frac_r <= 8'h00;
      nominal_rate_r <= 32'h00000000;
      rated_frac_r <= 8'h00;
      backlash_enable_r <= 1'b0;
      backlash_count_r <= 16'h0000;
      feedback_up_r <= 1'b0;
      vcap_r <= 1'b0;
      ccap_r <= 1'b0;
      rcap_r <= 1'b0;
    end else begin
      eff_target_rate_r <= (target_rate_q > MES_RATE_MAX) ? MES_RATE_MAX : target_rate_q; // RQ3
      target_frac_r <= dc_motor_r ? 8'h00 : target_frac_q; // RQ4
      eff_accel_r <= flags_q[MES_FL_RAMP] ? accel_q : 16'h0000; // RQ17
      eff_decel_r <= flags_q[MES_FL_RAMP] ? decel_q : 16'h0000; // RQ17
      bl_frac_r <= dc_motor_r ? 8'h00 : bl_frac_q; // RQ6
      nominal_rate_r <= flags_q[MES_FL_MAXRATE] ? max_rate_r : rated_rate_q; // RQ14
      rated_frac_r <= dc_motor_r ? 8'h00 : rated_frac_q;
      backlash_enable_r <= flags_q[MES_FL_BACKLASH]; // RQ15
      backlash_count_r <= flags_q[MES_FL_BACKLASH] ? bl_count_q : 16'h0000; // RQ16
      feedback_up_r <= shaft_dir_positive ^ flags_q[MES_FL_REVERSE]; // RQ12
      vcap_r <= dc_motor_r && flags_q[MES_FL_VCAP] && meas_voltage >= volt_q; // RQ9
      ccap_r <= dc_motor_r && flags_q[MES_FL_CCAP] && meas_current >= curr_q; // RQ10
      rcap_r <= flags_q[MES_FL_RCAP] && meas_shaft_rate >= rated_rate_q; // RQ11
    end
  end

  // Software registers; counters saturate so a burst of errors stays visible.
  always_ff @(posedge clock) begin
    if (srst) begin
      dc_motor_r <= 1'b0;
      max_rate_r <= MES_MAXRATE_RST;
      bad_crc_cnt_r <= 8'h00;
      good_cnt_r <= 8'h00;
      reg_rdata_r <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == MES_REG_CTRL) begin
        dc_motor_r <= reg_wdata[MES_CTRL_DC];
      end
      if (reg_wr && reg_addr == MES_REG_MAXRATE) begin
        max_rate_r <= reg_wdata;
      end
      if (state_r == MES_ST_CHK && !crc_ok && bad_crc_cnt_r != 8'hff) begin
        bad_crc_cnt_r <= bad_crc_cnt_r + 8'h01;
      end
      if (state_r == MES_ST_CHK && crc_ok && good_cnt_r != 8'hff) begin
        good_cnt_r <= good_cnt_r + 8'h01;
      end
      reg_rdata_r <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          MES_REG_CTRL: reg_rdata_r <= {31'h00000000, dc_motor_r};
          MES_REG_STATUS: reg_rdata_r <= {15'h0000, tx_valid_r, good_cnt_r, bad_crc_cnt_r};
          MES_REG_MAXRATE: reg_rdata_r <= max_rate_r;
          default: reg_rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign reg_rdata = reg_rdata_r;
  assign eff_target_rate = eff_target_rate_r;
  assign target_rate_fraction = target_frac_r;
  assign eff_accel = eff_accel_r;
  assign eff_decel = eff_decel_r;
  assign backlash_move_rate = bl_rate_q;
  assign backlash_move_rate_fraction = bl_frac_r;
  assign rated_motor_voltage = volt_q;
  assign rated_motor_current = curr_q;
  assign nominal_shaft_rate = nominal_rate_r;
  assign rated_shaft_rate_fraction = rated_frac_r;
  assign current_rms_meaning_flag = flags_q[MES_FL_RMS]; // RQ13
  assign backlash_enable = backlash_enable_r;
  assign backlash_count = backlash_count_r;
  assign feedback_count_up = feedback_up_r;
  assign voltage_cap_hit = vcap_r;
  assign current_cap_hit = ccap_r;
  assign rate_cap_hit = rcap_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_MOVE_LEN: assert property ( // RQ1
    state_r == MES_ST_RX && rx_valid && idx_r == 6'h03 && cmd_word == MES_CMD_SET_MOVE
    |=> frame_len_r == MES_LEN_MOVE && !is_engine_r)
    else $error("move frame length not set");
  AST_ECHO_LEN: assert property ( // RQ1
    state_r == MES_ST_CHK && crc_ok |=> tx_valid_r && tx_len_r == MES_LEN_CMD && !answer_r)
    else $error("echo not started after good frame");
  AST_ANS_LEN: assert property ( // RQ7
    state_r == MES_ST_RX && rx_valid && idx_r == 6'h03 && cmd_word == MES_CMD_GET_MOVE
    |=> state_r == MES_ST_TX && tx_len_r == MES_LEN_MOVE)
    else $error("move read answer not started");
  AST_RATE_CLAMP: assert property ( // RQ3
    eff_target_rate_r <= MES_RATE_MAX)
    else $error("target rate above limit");
  AST_FRAC_DC: assert property ( // RQ4
    $past(dc_motor_r) |-> target_frac_r == 8'h00 && bl_frac_r == 8'h00)
    else $error("fraction used on dc motor");
  AST_VCAP: assert property ( // RQ9
    vcap_r |-> $past(dc_motor_r && flags_q[MES_FL_VCAP] && meas_voltage >= volt_q))
    else $error("voltage cap without cause");
  AST_CCAP: assert property ( // RQ10
    ccap_r |-> $past(dc_motor_r && flags_q[MES_FL_CCAP]))
    else $error("current cap without cause");
  AST_RCAP: assert property ( // RQ11
    flags_q[MES_FL_RCAP] && meas_shaft_rate >= rated_rate_q |=> rcap_r)
    else $error("rate cap missed");
  AST_BL_COUNT: assert property ( // RQ16
    !$past(flags_q[MES_FL_BACKLASH]) |-> backlash_count_r == 16'h0000)
    else $error("backlash count used while disabled");
  AST_RAMP: assert property ( // RQ17
    !$past(flags_q[MES_FL_RAMP]) |-> eff_accel_r == 16'h0000 && eff_decel_r == 16'h0000)
    else $error("ramp applied while disabled");
  AST_BAD_CRC: assert property ( // RQ18
    state_r == MES_ST_CHK && !crc_ok |=> $stable(target_rate_q) && $stable(flags_q)
    && !tx_valid_r)
    else $error("bad frame changed settings");

  COV_MOVE_WRITE: cover property (state_r == MES_ST_CHK && crc_ok && !is_engine_r);
  COV_ENG_WRITE: cover property (state_r == MES_ST_CHK && crc_ok && is_engine_r);
  COV_ANSWER_DONE: cover property (tx_fire && tx_last && answer_r);
  COV_BAD_CRC: cover property (state_r == MES_ST_CHK && !crc_ok);
endmodule

// File: sim/mes_host_model.sv
// Purpose: Host side of the settings byte link: sends command frames, collects answers.
// Assumes: Block's rx_ready and tx_valid change only on the rising clock edge.
// Notes: Handshakes are judged at the falling edge, where the block's outputs are settled.
module mes_host_model
  import mes_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Bytes towards the block.
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Bytes from the block.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Frames leave whole and in order, each byte held until it is taken.
  task automatic send(input logic [7:0] fr[$]);
    logic ok;
    @(posedge clock);
    foreach (fr[i]) begin
      rx_valid <= 1'b1;
      rx_data <= fr[i];
      do begin
        @(negedge clock);
        ok = rx_ready;
        @(posedge clock);
      end while (!ok);
    end
    rx_valid <= 1'b0;
    // A released data line does not keep the old byte, so a late sampler sees garbage.
    rx_data <= ~fr[fr.size() - 1];
  endtask
  // Collects up to n answer bytes, stalling before each one; gives up after 60 idle cycles.
  task automatic recv(input int n, input int stall, output logic [7:0] got[$]);
    int w;
    logic ok;
    logic [7:0] d;
    got = {};
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      if (stall > 0) begin
        tx_ready <= 1'b0;
        repeat (stall) @(posedge clock);
      end
      tx_ready <= 1'b1;
      w = 0;
      do begin
        @(negedge clock);
        ok = tx_valid;
        d = tx_data;
        @(posedge clock);
        w++;
      end while (!ok && w < 60);
      if (!ok) break;
      got.push_back(d);
    end
    tx_ready <= 1'b0;
  endtask
endmodule

// File: sim/tb_mes_settings_cmd.sv
// Purpose: Self-checking bench for the move and engine settings command handler.
// Assumes: Checksum is the 16-bit byte sum of the payload, as the block expects.
// Notes: Outputs are judged at a falling edge so the launching edge has settled.
module tb_mes_settings_cmd
  import mes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] mes_bytes_t[$];
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic rx_valid, rx_ready, tx_valid, tx_ready, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] rx_data, tx_data, target_rate_fraction, backlash_move_rate_fraction;
  logic [7:0] rated_shaft_rate_fraction;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, meas_shaft_rate = 32'h0, eff_target_rate;
  logic [31:0] backlash_move_rate, nominal_shaft_rate;
  logic [15:0] meas_voltage = 16'h0, meas_current = 16'h0, eff_accel, eff_decel;
  logic [15:0] rated_motor_voltage, rated_motor_current, backlash_count;
  logic shaft_dir_positive = 1'b0, current_rms_meaning_flag, backlash_enable;
  logic feedback_count_up, voltage_cap_hit, current_cap_hit, rate_cap_hit;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  mes_bytes_t mv;
  always #4 clock = ~clock;
  mes_settings_cmd i_dut (.clock(clock), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_voltage(meas_voltage), .meas_current(meas_current),
    .meas_shaft_rate(meas_shaft_rate), .shaft_dir_positive(shaft_dir_positive),
    .eff_target_rate(eff_target_rate), .target_rate_fraction(target_rate_fraction),
    .eff_accel(eff_accel), .eff_decel(eff_decel), .backlash_move_rate(backlash_move_rate),
    .backlash_move_rate_fraction(backlash_move_rate_fraction),
    .rated_motor_voltage(rated_motor_voltage), .rated_motor_current(rated_motor_current),
    .nominal_shaft_rate(nominal_shaft_rate), .rated_shaft_rate_fraction(rated_shaft_rate_fraction),
    .current_rms_meaning_flag(current_rms_meaning_flag), .backlash_enable(backlash_enable),
    .backlash_count(backlash_count), .feedback_count_up(feedback_count_up),
    .voltage_cap_hit(voltage_cap_hit), .current_cap_hit(current_cap_hit),
    .rate_cap_hit(rate_cap_hit));
  mes_host_model i_host (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // The ceiling is far above the few hundred cycles the scenarios need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  function automatic mes_bytes_t le(input logic [31:0] v, input int n);
    mes_bytes_t q;
    for (int i = 0; i < n; i++) q.push_back(v[8 * i +: 8]);
    return q;
  endfunction
  function automatic mes_bytes_t frame(input logic [31:0] cmd, input mes_bytes_t body,
    input logic bad);
    mes_bytes_t f;
    logic [15:0] s;
    s = bad ? 16'h0001 : 16'h0000;
    f = le(cmd, 4);
    foreach (body[i]) begin
      f.push_back(body[i]);
      s = s + 16'(body[i]);
    end
    return {f, le({16'h0000, s}, 2)};
  endfunction
  task automatic t_reset();
    logic [31:0] d;
    check(rx_ready, 1, "ready after reset");
    check(eff_target_rate, 0, "rate after reset");
    reg_read(MES_REG_MAXRATE, d);
    check(d, MES_MAXRATE_RST, "maxrate reset");
    reg_write(4'hc, 32'hffffffff);
    reg_write(MES_REG_STATUS, 32'hffffffff);
    reg_read(4'hc, d);
    check(d, 0, "unmapped read");
    reg_read(MES_REG_STATUS, d);
    check(d, 0, "status read only");
  endtask
  task automatic t_move();
    mes_bytes_t g, e;
    logic [31:0] d;
    // Reserved bytes go out as zeros.
    mv = {le(100000, 4), le(32'h5a, 1), le(32'hffff, 2), le(32'h0001, 2), le(32'h12345, 4),
      le(32'h80, 1), le(0, 4), le(0, 4), le(0, 2)};
    i_host.send(frame(MES_CMD_SET_MOVE, mv, 1'b0));
    i_host.recv(4, 0, g);
    e = le(MES_CMD_SET_MOVE, 4);
    check(g.size(), 4, "echo length");
    foreach (e[i]) check(g[i], e[i], "move echo");
    settle();
    check(eff_target_rate, 100000, "target rate at ceiling");
    check(target_rate_fraction, 8'h5a, "stepper fraction");
    check(eff_accel, 0, "no ramp without flag");
    check(backlash_move_rate, 32'h12345, "backlash rate");
    check(backlash_move_rate_fraction, 8'h80, "backlash fraction");
    reg_read(MES_REG_STATUS, d);
    check(d[15:8], 1, "good frame count");
    i_host.send(le(MES_CMD_GET_MOVE, 4));
    i_host.recv(30, 2, g);
    e = frame(MES_CMD_GET_MOVE, mv, 1'b0);
    check(g.size(), 30, "read answer length");
    foreach (e[i]) if (i < 18 || i > 27) check(g[i], e[i], "read answer byte");
  endtask
  task automatic t_bad_sum();
    mes_bytes_t g;
    logic [31:0] d;
    i_host.send(frame(MES_CMD_SET_MOVE, {le(500, 4), le(0, 20)}, 1'b1));
    i_host.recv(4, 0, g);
    check(g.size(), 0, "no echo on bad sum");
    settle();
    check(eff_target_rate, 100000, "settings kept");
    reg_read(MES_REG_STATUS, d);
    check(d[7:0], 1, "bad frame count");
  endtask
  task automatic t_engine(input logic [15:0] fl);
    mes_bytes_t g;
    reg_write(MES_REG_CTRL, 32'h1);
    reg_write(MES_REG_MAXRATE, 32'h4321);
    i_host.send(frame(MES_CMD_SET_ENG, {le(32'h200, 2), le(32'h300, 2), le(32'h2000, 4),
      le(32'h11, 1), le({16'h0, fl}, 2), le(32'hfff0, 2), le(0, 15)}, 1'b0));
    i_host.recv(4, 1, g);
    check(g.size(), 4, "engine echo length");
    check(g[0], 8'h73, "engine echo");
    meas_voltage <= 16'h0200;
    meas_current <= 16'h0300;
    meas_shaft_rate <= 32'hffffffff;
    shaft_dir_positive <= 1'b1;
    settle();
    check(rated_motor_voltage, 32'h200, "rated voltage");
    check(rated_motor_current, 32'h300, "rated current");
    check(rated_shaft_rate_fraction, 0, "no fraction on DC");
    check(nominal_shaft_rate, fl[2] ? 32'h4321 : 32'h2000, "nominal rate");
    check(current_rms_meaning_flag, fl[1], "current meaning");
    check(backlash_enable, fl[3], "backlash on");
    check(backlash_count, fl[3] ? 32'hfff0 : 0, "backlash count");
    check(eff_accel, fl[4] ? 32'hffff : 0, "accel ramp");
    check(eff_decel, fl[4] ? 32'h1 : 0, "decel ramp");
    check(target_rate_fraction, 0, "DC drops fraction");
    check(backlash_move_rate_fraction, 0, "DC drops backlash fraction");
    check(feedback_count_up, !fl[0], "feedback direction");
    check(voltage_cap_hit, fl[5], "voltage cap");
    check(current_cap_hit, fl[6], "current cap");
    check(rate_cap_hit, fl[7], "rate cap");
    meas_voltage <= 16'h01ff;
    meas_current <= 16'h02ff;
    meas_shaft_rate <= 32'h0;
    settle();
    check({voltage_cap_hit, current_cap_hit, rate_cap_hit}, 0, "caps released");
  endtask
  task automatic t_clamp();
    mes_bytes_t g;
    // An unknown word is swallowed silently; the next frame must still be decoded.
    i_host.send(le(32'h78563412, 4));
    i_host.recv(1, 0, g);
    check(g.size(), 0, "unknown word ignored");
    i_host.send(frame(MES_CMD_SET_MOVE, {le(32'h186a1, 4), le(32'h7, 1), le(0, 19)}, 1'b0));
    i_host.recv(4, 0, g);
    check(g.size(), 4, "echo after unknown word");
    settle();
    check(eff_target_rate, 100000, "target rate clamped");
    check(target_rate_fraction, 0, "DC fraction dropped");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    t_reset();
    t_move();
    t_bad_sum();
    t_engine(16'h00ff);
    t_engine(16'h0055);
    t_engine(16'h00aa);
    t_engine(16'h0000);
    t_clamp();
    print_verdict();
  end
endmodule
